// ---- core/pin_sync.sv ----
`timescale 1ns/10ps
module pin_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic ce_i,
    // Pin and its clean level
    input  wire logic d_i,
    output logic      q_o
);

    logic [2:0] sync_q;
    logic       lvl_q;

    // Two last stages must agree, so a single-cycle glitch is ignored
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync_q <= {3{RST_VAL}};
            lvl_q  <= RST_VAL;
        end else if (ce_i) begin
            sync_q <= {sync_q[1:0], d_i};
            if (sync_q[1] == sync_q[2]) begin
                lvl_q <= sync_q[2];
            end
        end
    end

    assign q_o = lvl_q;

endmodule

// ---- core/sensor_reset_and_standby_ctrl.sv ----
`timescale 1ns/10ps
module sensor_reset_and_standby_ctrl #(
    parameter int BOOT_CYCLES = stby_pkg::BOOT_CYCLES
) (
    // Clock, power-on reset, enable
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    input  wire logic                 ce_i,
    // Pins from the host
    input  wire logic                 reset_pin_b_i,
    input  wire logic                 standby_pin_i,
    // Register port from the serial interface
    input  wire stby_pkg::reg_req_t   reg_req_i,
    output logic [15:0]               reg_rdata_o,
    // Chip control
    output logic                      core_rst_b_o,
    output stby_pkg::power_ctl_t      pwr_o,
    output logic [15:0]               retained_cfg_o,
    output logic                      in_standby_o
);

    if (BOOT_CYCLES < 1 || BOOT_CYCLES > 65535) begin : g_bad_boot
        $error("BOOT_CYCLES out of range");
    end

    localparam logic [15:0] BOOT_LAST = 16'(BOOT_CYCLES - 1);

    function automatic logic hit(input logic [15:0] addr, input logic [15:0] ofs);
        hit = (addr == ofs);
    endfunction

    // Power-on reset release
    logic [1:0] rst_sync_q;
    logic       rst_ok;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync_q <= 2'h0;
        end else if (ce_i) begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_ok = rst_sync_q[1];

    logic pin_ok;
    logic stby_lvl;

    pin_sync #(.RST_VAL(1'b0)) u_rst_pin (
        .clk_i   (clk_i),
        .rst_b_i (rst_ok),
        .ce_i    (ce_i),
        .d_i     (reset_pin_b_i),
        .q_o     (pin_ok)
    );

    pin_sync #(.RST_VAL(1'b0)) u_stby_pin (
        .clk_i   (clk_i),
        .rst_b_i (rst_ok),
        .ce_i    (ce_i),
        .d_i     (standby_pin_i),
        .q_o     (stby_lvl)
    );

    stby_pkg::ctrl_t q;
    stby_pkg::ctrl_t d;
    logic            srst_on;
    logic            hard_st;
    logic            hard_go;
    logic            serial_ok;
    logic            in_soft;

    assign srst_on   = q.srst[stby_pkg::SRST_HOLD_BIT];
    assign hard_st   = (q.st == stby_pkg::ST_HARD_LL) || (q.st == stby_pkg::ST_HARD_RET);
    assign hard_go   = stby_lvl && !q.ovr_hard && !hard_st;
    assign in_soft   = (q.st == stby_pkg::ST_SOFT);
    // Serial port stays alive in soft reset so the host can release it
    assign serial_ok = (q.st == stby_pkg::ST_ACTIVE) || in_soft
                       || (q.st == stby_pkg::ST_RESET && srst_on);

    always_comb begin
        d = q;
        if (!pin_ok) begin
            // Pin reset clears everything, retained configuration included
            d          = '0;
            d.st       = stby_pkg::ST_RESET;
            d.saved    = stby_pkg::ST_RESET;
            d.stby_req = stby_pkg::STBY_REQ_RST;
            d.cfg      = stby_pkg::CFG_RST;
        end else if (srst_on) begin
            d          = '0;
            d.st       = stby_pkg::ST_RESET;
            d.saved    = stby_pkg::ST_RESET;
            d.srst     = q.srst;
            d.stby_req = stby_pkg::STBY_REQ_RST;
            d.cfg      = stby_pkg::CFG_RST;
        end else if (hard_go) begin
            if (q.ret_sel) begin
                d.saved = q.st;
                d.st    = stby_pkg::ST_HARD_RET;
            end else begin
                // Only the retained configuration outlives core power loss
                d          = '0;
                d.st       = stby_pkg::ST_HARD_LL;
                d.saved    = stby_pkg::ST_RESET;
                d.stby_req = stby_pkg::STBY_REQ_RST;
                d.cfg      = q.cfg;
            end
        end else begin
            case (q.st)
                stby_pkg::ST_RESET: begin
                    d.st  = stby_pkg::ST_BOOT;
                    d.cnt = 16'h0000;
                end
                stby_pkg::ST_BOOT: begin
                    if (q.cnt == BOOT_LAST) begin
                        d.st = stby_pkg::ST_SOFT;
                    end else begin
                        d.cnt = q.cnt + 16'h0001;
                    end
                end
                stby_pkg::ST_ACTIVE: begin
                    if (q.stby_req && !q.ovr_soft) begin
                        d.saved = stby_pkg::ST_ACTIVE;
                        d.st    = stby_pkg::ST_SOFT;
                    end
                end
                stby_pkg::ST_SOFT: begin
                    if (!q.stby_req) begin
                        d.st = stby_pkg::ST_ACTIVE;
                    end
                end
                stby_pkg::ST_HARD_LL: begin
                    if (!stby_lvl) begin
                        d.st  = stby_pkg::ST_BOOT;
                        d.cnt = 16'h0000;
                    end
                end
                stby_pkg::ST_HARD_RET: begin
                    if (!stby_lvl) begin
                        d.st = q.saved;
                    end
                end
                default: begin
                    d.st = stby_pkg::ST_RESET;
                end
            endcase
        end
        // Register access; writes while the serial port is off are dropped
        if (pin_ok && serial_ok && reg_req_i.wr) begin
            if (hit(reg_req_i.addr, stby_pkg::STBY_OFS)) begin
                d.stby_req = reg_req_i.wdata[stby_pkg::STBY_REQ_BIT];
                d.ret_sel  = reg_req_i.wdata[stby_pkg::RET_SEL_BIT];
                d.ovr_soft = reg_req_i.wdata[stby_pkg::OVR_SOFT_BIT];
                d.ovr_hard = reg_req_i.wdata[stby_pkg::OVR_HARD_BIT];
            end
            if (hit(reg_req_i.addr, stby_pkg::SRST_OFS)) begin
                d.srst = reg_req_i.wdata[1:0];
            end
            if (hit(reg_req_i.addr, stby_pkg::CFG_OFS)) begin
                d.cfg = reg_req_i.wdata;
            end
        end
        if (pin_ok && serial_ok && reg_req_i.rd) begin
            d.rdata = 16'h0000;
            if (hit(reg_req_i.addr, stby_pkg::STBY_OFS)) begin
                d.rdata[stby_pkg::STBY_REQ_BIT]  = q.stby_req;
                d.rdata[stby_pkg::RET_SEL_BIT]   = q.ret_sel;
                d.rdata[stby_pkg::OVR_SOFT_BIT]  = q.ovr_soft;
                d.rdata[stby_pkg::OVR_HARD_BIT]  = q.ovr_hard;
                d.rdata[stby_pkg::STBY_STAT_BIT] = in_soft;
            end
            if (hit(reg_req_i.addr, stby_pkg::SRST_OFS)) begin
                d.rdata[1:0] = q.srst;
            end
            if (hit(reg_req_i.addr, stby_pkg::CFG_OFS)) begin
                d.rdata = q.cfg;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_ok) begin
        if (!rst_ok) begin
            q          <= '0;
            q.st       <= stby_pkg::ST_RESET;
            q.saved    <= stby_pkg::ST_RESET;
            q.stby_req <= stby_pkg::STBY_REQ_RST;
            q.cfg      <= stby_pkg::CFG_RST;
        end else if (ce_i) begin
            q <= d;
        end
    end

    // Power-on reset only feeds internal logic; there is no drive onto the pin
    assign core_rst_b_o       = rst_ok && pin_ok && !srst_on
                                && (q.st != stby_pkg::ST_RESET);
    assign pwr_o.core_en      = (q.st == stby_pkg::ST_ACTIVE);
    assign pwr_o.serial_en    = serial_ok;
    assign pwr_o.clk_en       = !hard_st;
    assign pwr_o.vdd_en       = (q.st != stby_pkg::ST_HARD_LL);
    assign pwr_o.par_oe       = rst_ok && pin_ok && (q.st == stby_pkg::ST_ACTIVE);
    assign pwr_o.mipi_low     = !pwr_o.par_oe;
    assign retained_cfg_o     = q.cfg;
    assign reg_rdata_o        = q.rdata;
    assign in_standby_o       = in_soft;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_ok);

    logic quiet;
    assign quiet = ce_i && pin_ok && !srst_on && !hard_go;

    sequence leave_ret_s;
        quiet && q.st == stby_pkg::ST_HARD_RET && !stby_lvl;
    endsequence

    sequence leave_ll_s;
        quiet && q.st == stby_pkg::ST_HARD_LL && !stby_lvl;
    endsequence

    boot_bound_a: assert property (q.st == stby_pkg::ST_BOOT |-> q.cnt <= BOOT_LAST)
        else $error("boot count passed its limit");
    boot_end_a: assert property (quiet && q.st == stby_pkg::ST_BOOT && q.cnt == BOOT_LAST
        |=> q.st == stby_pkg::ST_SOFT)
        else $error("boot did not end in soft standby");
    pin_float_a: assert property (ce_i && !pin_ok |-> !pwr_o.par_oe && pwr_o.mipi_low
        ##1 !pwr_o.core_en && pwr_o.mipi_low)
        else $error("outputs driven during pin reset");
    int_reset_a: assert property (ce_i && !pin_ok |=> q.st == stby_pkg::ST_RESET
        && !core_rst_b_o)
        else $error("pin reset not taken");
    soft_rst_a: assert property (ce_i && pin_ok && serial_ok && reg_req_i.wr
        && reg_req_i.addr == stby_pkg::SRST_OFS && reg_req_i.wdata[1:0] == stby_pkg::SRST_START
        |=> !core_rst_b_o ##1 !core_rst_b_o)
        else $error("soft reset not started");
    hard_ovr_a: assert property (ce_i && pin_ok && !srst_on && q.ovr_hard
        && q.st == stby_pkg::ST_ACTIVE |=> !hard_st)
        else $error("hard standby entered despite override");
    cfg_keep_a: assert property (hard_st && pin_ok |=> q.cfg == $past(q.cfg))
        else $error("retained configuration lost");
    soft_entry_a: assert property (quiet && q.st == stby_pkg::ST_ACTIVE && q.stby_req
        && !q.ovr_soft |=> in_soft ##0 pwr_o.serial_en && !pwr_o.core_en)
        else $error("soft standby not entered");
    ll_power_a: assert property (q.st == stby_pkg::ST_HARD_LL |-> !pwr_o.vdd_en
        && !pwr_o.serial_en && !q.ovr_soft)
        else $error("low-leakage standby not powered down");
    ll_wake_a: assert property (leave_ll_s |=> q.st == stby_pkg::ST_BOOT
        && q.cnt == 16'h0000)
        else $error("low-leakage exit did not reboot");
    ret_resume_a: assert property (leave_ret_s |=> q.st == $past(q.saved))
        else $error("retaining standby did not resume");
    ll_default_a: assert property (ce_i && pin_ok && !srst_on && hard_go && !q.ret_sel
        |=> q.st == stby_pkg::ST_HARD_LL)
        else $error("standby pin did not select low leakage");
    stat_read_a: assert property (ce_i && pin_ok && serial_ok && reg_req_i.rd
        && reg_req_i.addr == stby_pkg::STBY_OFS
        |=> reg_rdata_o[stby_pkg::STBY_STAT_BIT] == $past(in_soft))
        else $error("standby status misread");

endmodule

// ---- core/stby_pkg.sv ----
package stby_pkg;

    // Register offsets
    localparam logic [15:0] CFG_OFS  = 16'h0014;
    localparam logic [15:0] STBY_OFS = 16'h0018;
    localparam logic [15:0] SRST_OFS = 16'h001a;

    // Field positions in the standby register
    localparam int STBY_REQ_BIT  = 0;
    localparam int RET_SEL_BIT   = 4;
    localparam int OVR_SOFT_BIT  = 5;
    localparam int OVR_HARD_BIT  = 6;
    localparam int STBY_STAT_BIT = 14;

    // Soft reset field
    localparam int         SRST_HOLD_BIT = 0;
    localparam logic [1:0] SRST_START    = 2'h3;

    // Reset values
    localparam logic        STBY_REQ_RST = 1'h1;
    localparam logic [15:0] CFG_RST      = 16'h0000;

    // Timing, in input clock cycles
    localparam int BOOT_CYCLES = 6000;

    typedef enum logic [2:0] {
        ST_RESET,
        ST_BOOT,
        ST_ACTIVE,
        ST_SOFT,
        ST_HARD_LL,
        ST_HARD_RET
    } mode_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic core_en;
        logic serial_en;
        logic clk_en;
        logic vdd_en;
        logic par_oe;
        logic mipi_low;
    } power_ctl_t;

    typedef struct packed {
        mode_t       st;
        mode_t       saved;
        logic [15:0] cnt;
        logic        stby_req;
        logic        ret_sel;
        logic        ovr_soft;
        logic        ovr_hard;
        logic [1:0]  srst;
        logic [15:0] cfg;
        logic [15:0] rdata;
    } ctrl_t;

endpackage

// ---- dv/host_model.sv ----
`timescale 1ns/10ps
module host_model (
    // Clock
    input  wire logic                 clk_i,
    // Read data back from the device
    input  wire logic [15:0]          rdata_i,
    // Pins and register port
    output logic                      reset_pin_b_o,
    output logic                      standby_pin_o,
    output stby_pkg::reg_req_t        req_o
);
    // Power up with reset held and standby released
    initial begin
        reset_pin_b_o = 1'b0;
        standby_pin_o = 1'b0;
        req_o         = '0;
    end

    // Pins move one edge after the call; the clock never stops around them
    task automatic pins(input logic rst_b, input logic stby);
        @(posedge clk_i);
        reset_pin_b_o <= rst_b;
        standby_pin_o <= stby;
    endtask

    // Requests are one-cycle pulses, as the serial side issues them
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_i);
        req_o <= '{1'b1, 1'b0, a, d};
        @(posedge clk_i);
        req_o <= '0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk_i);
        req_o <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge clk_i);
        req_o <= '0;
        @(negedge clk_i);
        d = rdata_i;
    endtask
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
    localparam int BOOT_P = 20;

    logic                 clk = 1'b0;
    logic                 rst_b = 1'b0;
    logic                 ce = 1'b1;
    logic                 rst_pin_b;
    logic                 stby_pin;
    stby_pkg::reg_req_t   req;
    stby_pkg::power_ctl_t pwr;
    logic [15:0]          rdata;
    logic [15:0]          cfg;
    logic [15:0]          v;
    logic                 core_rst_b;
    logic                 in_stby;
    int                   n_errors = 0;
    int                   checks_done = 0;
    int                   cyc = 0;

    always #12.5 clk = ~clk;

    sensor_reset_and_standby_ctrl #(.BOOT_CYCLES(BOOT_P)) dut (
        .clk_i          (clk),
        .rst_b_i        (rst_b),
        .ce_i           (ce),
        .reset_pin_b_i  (rst_pin_b),
        .standby_pin_i  (stby_pin),
        .reg_req_i      (req),
        .reg_rdata_o    (rdata),
        .core_rst_b_o   (core_rst_b),
        .pwr_o          (pwr),
        .retained_cfg_o (cfg),
        .in_standby_o   (in_stby)
    );

    host_model host (
        .clk_i         (clk),
        .rdata_i       (rdata),
        .reset_pin_b_o (rst_pin_b),
        .standby_pin_o (stby_pin),
        .req_o         (req)
    );

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // Bounded wait so a missing boot end shows as a mismatch, not a hang
    task automatic wait_stby();
        int k;
        k = 0;
        while (in_stby !== 1'b1 && k < BOOT_P + 10) begin
            @(negedge clk);
            k++;
        end
        chk(in_stby, 16'h1);
    endtask

    task automatic wrap_up();
        $display("Checks done: %0d, errors: %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            wrap_up();
        end
    end

    initial begin
        waitc(2);
        chk(core_rst_b, 16'h0);
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        waitc(12);
        host.pins(1'b1, 1'b0);
        wait_stby();
        chk(pwr.core_en, 16'h0);
        chk(pwr.serial_en, 16'h1);
        waitc(1);
        host.rd(16'h0018, v);
        chk(v, 16'h4001);
        host.rd(16'h0014, v);
        chk(v, 16'h0000);
        host.rd(16'h0002, v);
        chk(v, 16'h0000);
        host.wr(16'h0014, 16'h5a3c);
        host.wr(16'h0018, 16'h0000);
        waitc(3);
        chk(in_stby, 16'h0);
        chk(pwr.core_en, 16'h1);
        host.rd(16'h0018, v);
        chk(v, 16'h0000);
        host.wr(16'h0018, 16'h0021);
        waitc(3);
        chk(in_stby, 16'h0);
        host.wr(16'h0018, 16'h0001);
        waitc(3);
        chk(in_stby, 16'h1);
        host.rd(16'h0014, v);
        chk(v, 16'h5a3c);
        host.wr(16'h0018, 16'h0050);
        host.pins(1'b1, 1'b1);
        waitc(6);
        chk(pwr.clk_en, 16'h1);
        chk(pwr.vdd_en, 16'h1);
        host.pins(1'b1, 1'b0);
        waitc(6);
        host.wr(16'h0018, 16'h0010);
        waitc(3);
        host.pins(1'b1, 1'b1);
        waitc(6);
        chk(pwr.clk_en, 16'h0);
        chk(pwr.serial_en, 16'h0);
        host.wr(16'h0014, 16'hffff);
        host.pins(1'b1, 1'b0);
        waitc(6);
        chk(pwr.core_en, 16'h1);
        chk(cfg, 16'h5a3c);
        host.wr(16'h0018, 16'h0000);
        host.pins(1'b1, 1'b1);
        waitc(6);
        chk(pwr.vdd_en, 16'h0);
        chk(pwr.serial_en, 16'h0);
        host.pins(1'b1, 1'b0);
        wait_stby();
        chk(cfg, 16'h5a3c);
        host.rd(16'h0018, v);
        chk(v & 16'h0070, 16'h0000);
        host.wr(16'h001a, 16'h0003);
        @(negedge clk);
        chk(core_rst_b, 16'h0);
        chk(pwr.serial_en, 16'h1);
        waitc(BOOT_P);
        host.wr(16'h001a, 16'h0000);
        wait_stby();
        chk(cfg, 16'h0000);
        host.wr(16'h0018, 16'h0000);
        waitc(3);
        chk(pwr.par_oe, 16'h1);
        host.pins(1'b0, 1'b0);
        waitc(5);
        chk(core_rst_b, 16'h0);
        chk(pwr.par_oe, 16'h0);
        chk(pwr.mipi_low, 16'h1);
        waitc(12);
        host.pins(1'b1, 1'b0);
        wait_stby();
        host.wr(16'h0018, 16'h0000);
        waitc(3);
        @(posedge clk);
        ce <= 1'b0;
        host.wr(16'h0018, 16'h0001);
        waitc(3);
        chk(in_stby, 16'h0);
        @(posedge clk);
        ce <= 1'b1;
        waitc(3);
        chk(in_stby, 16'h0);
        host.wr(16'h0014, 16'h00a5);
        @(posedge clk);
        rst_b <= 1'b0;
        @(negedge clk);
        chk(core_rst_b, 16'h0);
        chk(cfg, 16'h0000);
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        wait_stby();
        chk(pwr.par_oe, 16'h0);
        wrap_up();
    end
endmodule
